// file: shared/pio_pkg.sv
// Shared constants, register indices and carrier types of the parallel I/O block
package pio_pkg;
	// Data width of every port and register
	localparam int DATA_W = 8;
	// Width of the register index on the access port
	localparam int IDX_W = 4;

	// Register indices on the access port
	localparam logic [IDX_W-1:0] IDX_PORT_A = 4'h0;
	localparam logic [IDX_W-1:0] IDX_CTRL = 4'h2;
	localparam logic [IDX_W-1:0] IDX_PORT_C = 4'h3;
	localparam logic [IDX_W-1:0] IDX_PORT_B = 4'h4;
	localparam logic [IDX_W-1:0] IDX_LATCHED_C = 4'h5;
	localparam logic [IDX_W-1:0] IDX_DIR_C = 4'h7;
	localparam logic [IDX_W-1:0] IDX_PORT_D = 4'h8;
	localparam logic [IDX_W-1:0] IDX_DIR_D = 4'h9;
	localparam logic [IDX_W-1:0] IDX_PORT_E = 4'hA;

	// Reset values
	localparam logic [DATA_W-1:0] CTRL_RESET = 8'h03;
	localparam logic [DATA_W-1:0] DIR_RESET = 8'h00;
	localparam logic [DATA_W-1:0] LATCH_RESET = 8'h00;
	localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;

	// Port A line groups
	localparam logic [DATA_W-1:0] PA_IN_MASK = 8'h07;
	localparam logic [DATA_W-1:0] PA_OUT_MASK = 8'h78;
	localparam logic [DATA_W-1:0] PA_BIDIR_MASK = 8'h80;
	localparam int PA_BIDIR_BIT = 7;

	// Strobe pulse length: two E clock periods, E clock equal to the system clock
	localparam int STROBE_E_PERIODS = 2;
	localparam int SYS_PER_E = 1;
	localparam int STROBE_CYCLES = STROBE_E_PERIODS * SYS_PER_E;
	localparam int CNT_W = 4;

	// Control register layout, top bit is the read-only capture flag
	typedef struct packed {
		logic strobe_capture_flag;
		logic capture_irq_enable;
		logic open_drain_c;
		logic handshake_select_bit;
		logic output_handshake;
		logic pulse_mode;
		logic edge_polarity_select;
		logic strobe_polarity_bit;
	} pio_ctl_t;

	// One register access request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [IDX_W-1:0] idx;
		logic [DATA_W-1:0] wdata;
	} pio_acc_t;

	// Pin drive of a two-way port, enable low while driving
	typedef struct packed {
		logic [DATA_W-1:0] out;
		logic [DATA_W-1:0] oe_n;
	} pio_bidir_t;
endpackage

// file: logic/pio_edge_det.sv
// Edge input synchroniser and selectable edge detector
`timescale 1ns/10ps
module pio_edge_det (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Edge input and polarity, 1 selects rising
	input wire logic edge_latch_input,
	input wire logic edge_polarity_select,
	// One-cycle pulse per significant edge
	output logic edge_pulse
);
	logic sync1_reg; // First stage, read only by the second
	logic sync2_reg; // Second stage, safe to use
	logic prev_reg; // Delayed copy for edge detection
	logic pulse_reg; // Registered edge pulse
	logic pulse_next;
	logic fill1_reg; // Set one edge after reset
	logic fill2_reg; // Set two edges after reset
	logic hist_ok_reg; // History now holds a real pin sample

	// Pick the edge that matters, once the history is filled from the pin,
	// so a pin idling high cannot fake an edge right after reset
	always_comb begin
		if (edge_polarity_select) begin
			pulse_next = sync2_reg & ~prev_reg & hist_ok_reg;
		end else begin
			pulse_next = ~sync2_reg & prev_reg & hist_ok_reg;
		end
	end

	// Two-stage synchroniser, history and pulse register
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			prev_reg <= 1'b0;
			pulse_reg <= 1'b0;
			fill1_reg <= 1'b0;
			fill2_reg <= 1'b0;
			hist_ok_reg <= 1'b0;
		end else begin
			fill1_reg <= 1'b1;
			fill2_reg <= fill1_reg;
			hist_ok_reg <= fill2_reg;
			sync1_reg <= edge_latch_input;
			sync2_reg <= sync1_reg;
			prev_reg <= sync2_reg;
			pulse_reg <= pulse_next;
		end
	end

	assign edge_pulse = pulse_reg;
endmodule

// file: logic/pio_top.sv
// Parallel I/O ports with simple strobed input and output
// Contract
// - Per-line direction bit selects input or output
// - Output line reads return driver input value
// - Input lines leave pin undriven
// - Writes to inputs held, driven once output
// - Reset clears all direction bits
// - Port A lines 0-2 input, writes ignored
// - Port A 3-6 output, reads return latch
// - Port A line 7 direction from bit
// - Port B output only, reads return latch
// - Port E eight inputs, writes ignored
// - Strobe pins used only in single-chip mode
// - Handshake bit clear selects simple strobed mode
// - Strobe output polarity set by invert bit
// - Port C readable live and latched
// - Edge select chooses rising or falling edge
// - Edge captures port C and sets flag
// - Flag with enable requests interrupt
// - Flag clears after control read then capture read
// - Edge updates capture even with flag set
// - Port B write gives two-cycle strobe pulse
// - Control register writable except read-only flag
`timescale 1ns/10ps
module pio_top #(
	parameter int STROBE_CYCLES = pio_pkg::STROBE_CYCLES
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Operating mode and port A line 7 direction
	input wire logic single_chip_mode,
	input wire logic port_a7_direction,
	// Register access request and read answer
	input wire pio_pkg::pio_acc_t acc_req,
	output logic [pio_pkg::DATA_W-1:0] acc_rdata,
	// Port A pins
	input wire logic [pio_pkg::DATA_W-1:0] port_a_in,
	output logic [pio_pkg::DATA_W-1:0] port_a_out,
	output logic port_a7_oe_n,
	// Port B pins
	output logic [pio_pkg::DATA_W-1:0] port_b_out,
	// Port C pins
	input wire logic [pio_pkg::DATA_W-1:0] port_c_in,
	output pio_pkg::pio_bidir_t port_c_pins,
	// Port D pins
	input wire logic [pio_pkg::DATA_W-1:0] port_d_in,
	output pio_pkg::pio_bidir_t port_d_pins,
	// Port E pins
	input wire logic [pio_pkg::DATA_W-1:0] port_e_in,
	// Strobe pins and interrupt request
	input wire logic edge_latch_input,
	output logic strobe_output_line,
	output logic capture_irq
);
	// Parameter check
	if (STROBE_CYCLES < 1 || STROBE_CYCLES >= (1 << pio_pkg::CNT_W)) begin : g_bad_strobe
		$error("STROBE_CYCLES out of range");
	end

	// Control register is read back whole, so its layout must match the port width
	if ($bits(pio_pkg::pio_ctl_t) != pio_pkg::DATA_W) begin : g_bad_ctl
		$error("Control layout does not match the data width");
	end

	// Counter reload value, cut to counter width
	localparam logic [pio_pkg::CNT_W-1:0] STROBE_LOAD = pio_pkg::CNT_W'(STROBE_CYCLES);
	localparam logic [pio_pkg::CNT_W-1:0] CNT_ZERO = 4'h0;
	localparam logic [pio_pkg::CNT_W-1:0] CNT_ONE = 4'h1;

	// Port data latches
	logic [pio_pkg::DATA_W-1:0] pa_latch_reg, pa_latch_next;
	logic [pio_pkg::DATA_W-1:0] pb_latch_reg, pb_latch_next;
	logic [pio_pkg::DATA_W-1:0] pc_latch_reg, pc_latch_next;
	logic [pio_pkg::DATA_W-1:0] pd_latch_reg, pd_latch_next;
	// Direction registers of the two-way ports
	logic [pio_pkg::DATA_W-1:0] dir_c_reg, dir_c_next;
	logic [pio_pkg::DATA_W-1:0] dir_d_reg, dir_d_next;
	// Control register and captured port C value
	pio_pkg::pio_ctl_t ctl_reg, ctl_next;
	logic [pio_pkg::DATA_W-1:0] capture_reg, capture_next;
	// Control read seen while the flag was set
	logic clear_armed_reg, clear_armed_next;
	// Strobe pulse counter
	logic [pio_pkg::CNT_W-1:0] strobe_cnt_reg, strobe_cnt_next;
	// Registered outputs
	logic [pio_pkg::DATA_W-1:0] rdata_reg, rdata_next;
	logic [pio_pkg::DATA_W-1:0] pa_out_reg, pa_out_next;
	logic pa7_oe_n_reg, pa7_oe_n_next;
	pio_pkg::pio_bidir_t pc_pins_reg, pc_pins_next;
	pio_pkg::pio_bidir_t pd_pins_reg, pd_pins_next;
	logic strobe_reg, strobe_next;
	logic irq_reg, irq_next;
	// Decoded conditions
	logic edge_pulse; // Significant edge seen
	logic strobed_mode; // Simple strobed mode active
	logic wr_hit_b; // Write to port B
	logic clear_flag; // Second step of the flag clear sequence
	logic [pio_pkg::DATA_W-1:0] pa_view; // Port A as read
	logic [pio_pkg::DATA_W-1:0] pc_view; // Port C as read
	logic [pio_pkg::DATA_W-1:0] pd_view; // Port D as read

	// Synchronised edge detector on the edge input
	pio_edge_det u_pio_edge_det (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.edge_latch_input(edge_latch_input),
		.edge_polarity_select(ctl_reg.edge_polarity_select),
		.edge_pulse(edge_pulse)
	);

	// Mode and access decode
	always_comb begin
		// Strobe functions exist only in single-chip mode with handshake off
		strobed_mode = single_chip_mode & ~ctl_reg.handshake_select_bit;
		wr_hit_b = acc_req.wr && acc_req.idx == pio_pkg::IDX_PORT_B;
		// Capture read completes a sequence that a flagged control read began
		clear_flag = acc_req.rd && acc_req.idx == pio_pkg::IDX_LATCHED_C && clear_armed_reg;
		// Port A: inputs live, outputs from the latch, line 7 per its direction
		pa_view = (port_a_in & pio_pkg::PA_IN_MASK) | (pa_latch_reg & pio_pkg::PA_OUT_MASK);
		// Line 7 reads its latch when driven, its pad when an input
		if (port_a7_direction) begin
			pa_view = pa_view | (pa_latch_reg & pio_pkg::PA_BIDIR_MASK);
		end else begin
			pa_view = pa_view | (port_a_in & pio_pkg::PA_BIDIR_MASK);
		end
		// Two-way ports: output lines read the driver input, inputs the pad
		pc_view = (dir_c_reg & pc_latch_reg) | (~dir_c_reg & port_c_in);
		pd_view = (dir_d_reg & pd_latch_reg) | (~dir_d_reg & port_d_in);
	end

	// Register writes, capture, flag and clear sequence
	always_comb begin
		// Every register holds unless a write or an event moves it
		pa_latch_next = pa_latch_reg;
		pb_latch_next = pb_latch_reg;
		pc_latch_next = pc_latch_reg;
		pd_latch_next = pd_latch_reg;
		dir_c_next = dir_c_reg;
		dir_d_next = dir_d_reg;
		ctl_next = ctl_reg;
		capture_next = capture_reg;
		clear_armed_next = clear_armed_reg;
		if (acc_req.wr) begin
			unique case (acc_req.idx)
				// Only output-capable lines of port A keep written data
				pio_pkg::IDX_PORT_A: begin
					pa_latch_next = acc_req.wdata & (pio_pkg::PA_OUT_MASK | pio_pkg::PA_BIDIR_MASK);
				end
				// Port B is a plain output latch
				pio_pkg::IDX_PORT_B: begin
					pb_latch_next = acc_req.wdata;
				end
				// Either port C address writes the same output latch
				pio_pkg::IDX_PORT_C, pio_pkg::IDX_LATCHED_C: begin
					pc_latch_next = acc_req.wdata;
				end
				// Port D output latch, kept even for input lines
				pio_pkg::IDX_PORT_D: begin
					pd_latch_next = acc_req.wdata;
				end
				// A one makes the port C line an output
				pio_pkg::IDX_DIR_C: begin
					dir_c_next = acc_req.wdata;
				end
				// A one makes the port D line an output
				pio_pkg::IDX_DIR_D: begin
					dir_d_next = acc_req.wdata;
				end
				// Flag bit is not writable
				pio_pkg::IDX_CTRL: begin
					ctl_next = {ctl_reg.strobe_capture_flag, acc_req.wdata[pio_pkg::DATA_W-2:0]};
				end
				// Port E and unused indices take no write
				default: begin
					ctl_next = ctl_reg;
				end
			endcase
		end
		// Control read with the flag set arms the clear
		if (acc_req.rd && acc_req.idx == pio_pkg::IDX_CTRL && ctl_reg.strobe_capture_flag) begin
			clear_armed_next = 1'b1;
		end
		// Capture read after an armed control read ends the sequence
		if (clear_flag) begin
			clear_armed_next = 1'b0;
			ctl_next.strobe_capture_flag = 1'b0;
		end
		// Edge in strobed mode recaptures even with the flag set; set wins over a clear in the same cycle
		if (edge_pulse && strobed_mode) begin
			capture_next = port_c_in;
			ctl_next.strobe_capture_flag = 1'b1;
		end
	end

	// Strobe pulse after each port B write in strobed mode
	always_comb begin
		strobe_cnt_next = strobe_cnt_reg;
		// A port B write in strobed mode restarts the pulse
		if (wr_hit_b && strobed_mode) begin
			strobe_cnt_next = STROBE_LOAD;
		end else if (strobe_cnt_reg != CNT_ZERO) begin
			// Count the active cycles down to idle
			strobe_cnt_next = strobe_cnt_reg - CNT_ONE;
		end
		// Active level is high when the invert bit is set
		if (strobe_cnt_next != CNT_ZERO && single_chip_mode) begin
			strobe_next = ctl_next.strobe_polarity_bit;
		end else begin
			// Idle or expanded mode: inactive level
			strobe_next = ~ctl_next.strobe_polarity_bit;
		end
	end

	// Pin drives, interrupt and read answer
	always_comb begin
		// Port A: lines 3-6 always driven, line 7 when set as output
		pa_out_next = pa_latch_next & (pio_pkg::PA_OUT_MASK | pio_pkg::PA_BIDIR_MASK);
		pa7_oe_n_next = ~port_a7_direction;
		// Port C drives from its latch; open-drain lines release on a one
		pc_pins_next.out = pc_latch_next;
		pc_pins_next.oe_n = ~dir_c_next | ({pio_pkg::DATA_W{ctl_next.open_drain_c}} & pc_latch_next);
		// Port D has no open-drain option
		pd_pins_next.out = pd_latch_next;
		pd_pins_next.oe_n = ~dir_d_next;
		// Interrupt request follows flag and enable
		irq_next = ctl_next.strobe_capture_flag & ctl_next.capture_irq_enable;
		// Read data is held between reads
		rdata_next = rdata_reg;
		// A read picks the register named by the index
		if (acc_req.rd) begin
			unique case (acc_req.idx)
				// Port A mixes pads and latch per line group
				pio_pkg::IDX_PORT_A: begin
					rdata_next = pa_view;
				end
				// Port B reads back its output latch
				pio_pkg::IDX_PORT_B: begin
					rdata_next = pb_latch_reg;
				end
				// Live port C: latch for outputs, pads for inputs
				pio_pkg::IDX_PORT_C: begin
					rdata_next = pc_view;
				end
				// Port C as captured at the last significant edge in strobed mode
				pio_pkg::IDX_LATCHED_C: begin
					rdata_next = capture_reg;
				end
				// Live port D: latch for outputs, pads for inputs
				pio_pkg::IDX_PORT_D: begin
					rdata_next = pd_view;
				end
				// Direction bits read back as written
				pio_pkg::IDX_DIR_C: begin
					rdata_next = dir_c_reg;
				end
				// Direction bits read back as written
				pio_pkg::IDX_DIR_D: begin
					rdata_next = dir_d_reg;
				end
				// Control with the capture flag on top
				pio_pkg::IDX_CTRL: begin
					rdata_next = ctl_reg;
				end
				// Port E is input only
				pio_pkg::IDX_PORT_E: begin
					rdata_next = port_e_in;
				end
				// Unused indices read zero
				default: begin
					rdata_next = pio_pkg::READ_ZERO;
				end
			endcase
		end
	end

	// Latches, directions, control and capture registers
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			// Every two-way line starts as an input
			pa_latch_reg <= pio_pkg::LATCH_RESET;
			pb_latch_reg <= pio_pkg::LATCH_RESET;
			pc_latch_reg <= pio_pkg::LATCH_RESET;
			pd_latch_reg <= pio_pkg::LATCH_RESET;
			dir_c_reg <= pio_pkg::DIR_RESET;
			dir_d_reg <= pio_pkg::DIR_RESET;
			ctl_reg <= pio_pkg::CTRL_RESET;
			capture_reg <= pio_pkg::LATCH_RESET;
			clear_armed_reg <= 1'b0;
		end else begin
			pa_latch_reg <= pa_latch_next;
			pb_latch_reg <= pb_latch_next;
			pc_latch_reg <= pc_latch_next;
			pd_latch_reg <= pd_latch_next;
			dir_c_reg <= dir_c_next;
			dir_d_reg <= dir_d_next;
			ctl_reg <= ctl_next;
			capture_reg <= capture_next;
			clear_armed_reg <= clear_armed_next;
		end
	end

	// Strobe counter and strobe level
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			// Counter idle, strobe at its inactive level
			strobe_cnt_reg <= CNT_ZERO;
			strobe_reg <= ~pio_pkg::CTRL_RESET[0];
		end else begin
			strobe_cnt_reg <= strobe_cnt_next;
			strobe_reg <= strobe_next;
		end
	end

	// Pin drive, interrupt and read answer registers
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			// All two-way pins released, no request, answer zero
			rdata_reg <= pio_pkg::READ_ZERO;
			pa_out_reg <= pio_pkg::LATCH_RESET;
			pa7_oe_n_reg <= 1'b1;
			pc_pins_reg <= {pio_pkg::LATCH_RESET, ~pio_pkg::DIR_RESET};
			pd_pins_reg <= {pio_pkg::LATCH_RESET, ~pio_pkg::DIR_RESET};
			irq_reg <= 1'b0;
		end else begin
			rdata_reg <= rdata_next;
			pa_out_reg <= pa_out_next;
			pa7_oe_n_reg <= pa7_oe_n_next;
			pc_pins_reg <= pc_pins_next;
			pd_pins_reg <= pd_pins_next;
			irq_reg <= irq_next;
		end
	end

	// Outputs straight from flip-flops
	assign acc_rdata = rdata_reg;
	assign port_a_out = pa_out_reg;
	assign port_a7_oe_n = pa7_oe_n_reg;
	assign port_b_out = pb_latch_reg;
	assign port_c_pins = pc_pins_reg;
	assign port_d_pins = pd_pins_reg;
	assign strobe_output_line = strobe_reg;
	assign capture_irq = irq_reg;
endmodule

// file: tb/pio_top_checker.sv
// Port-level assertions for the parallel I/O block
`timescale 1ns/10ps
module pio_top_checker #(
	parameter int STROBE_CYCLES = 2
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Access port and line 7 direction
	input wire logic port_a7_direction,
	input wire pio_pkg::pio_acc_t acc_req,
	input wire logic [7:0] acc_rdata,
	// Pins
	input wire logic [7:0] port_a_in,
	input wire logic [7:0] port_a_out,
	input wire logic port_a7_oe_n,
	input wire logic [7:0] port_b_out,
	input wire logic [7:0] port_c_in,
	input wire pio_pkg::pio_bidir_t port_c_pins,
	input wire pio_pkg::pio_bidir_t port_d_pins,
	input wire logic [7:0] port_e_in,
	input wire logic edge_latch_input,
	input wire logic strobe_output_line,
	input wire logic capture_irq
);
	// Edges from a port B write to the end of its strobe
	localparam int SD = STROBE_CYCLES + 1;
	// Recent levels of the edge input
	logic [7:0] eh_reg;
	// Decoded accesses
	logic wr_b, wr_c, rd_a, rd_b, rd_c, rd_e, rd_l;
	assign wr_b = acc_req.wr && acc_req.idx == pio_pkg::IDX_PORT_B;
	assign wr_c = acc_req.wr && acc_req.idx == pio_pkg::IDX_CTRL;
	assign rd_a = acc_req.rd && acc_req.idx == pio_pkg::IDX_PORT_A;
	assign rd_b = acc_req.rd && acc_req.idx == pio_pkg::IDX_PORT_B;
	assign rd_c = acc_req.rd && acc_req.idx == pio_pkg::IDX_PORT_C;
	assign rd_e = acc_req.rd && acc_req.idx == pio_pkg::IDX_PORT_E;
	assign rd_l = acc_req.rd && acc_req.idx == pio_pkg::IDX_LATCHED_C;
	// Shift in the edge input each cycle
	always_ff @(posedge clk_sys) begin
		eh_reg <= {eh_reg[6:0], edge_latch_input};
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	a_dir_reset: assert property ($rose(rst_n) |-> port_c_pins.oe_n == 8'hFF && port_d_pins.oe_n == 8'hFF)
		else $error("direction not cleared by reset");
	a_dir_d: assert property (acc_req.wr && acc_req.idx == pio_pkg::IDX_DIR_D |=> port_d_pins.oe_n == ~$past(acc_req.wdata))
		else $error("port D drive differs from direction");
	a_a_fixed: assert property ($past(rst_n) |-> port_a_out[2:0] == 3'h0 && port_a7_oe_n == !$past(port_a7_direction))
		else $error("port A fixed lines wrong");
	a_b_write: assert property (wr_b |=> port_b_out == $past(acc_req.wdata))
		else $error("port B latch not written");
	a_read_b: assert property (rd_b |=> acc_rdata == $past(port_b_out))
		else $error("port B read wrong");
	a_read_a: assert property (rd_a |=> acc_rdata[6:0] == {$past(port_a_out[6:3]), $past(port_a_in[2:0])})
		else $error("port A read wrong");
	a_read_c: assert property (rd_c |=> acc_rdata == ($past(port_c_pins.out) & ~$past(port_c_pins.oe_n)
		| $past(port_c_in) & $past(port_c_pins.oe_n)))
		else $error("port C read wrong");
	a_read_e: assert property (rd_e |=> acc_rdata == $past(port_e_in))
		else $error("port E read wrong");
	a_strobe_len: assert property (wr_b |=> ##1 $stable(strobe_output_line))
		else $error("strobe shorter than two cycles");
	a_strobe_why: assert property ($changed(strobe_output_line) |-> $past(wr_b) || $past(wr_b, SD) || $past(wr_c))
		else $error("strobe moved without cause");
	a_irq_rise: assert property ($rose(capture_irq) |-> $past(wr_c) || (|(eh_reg[7:1] ^ eh_reg[6:0])))
		else $error("interrupt without edge or enable");
	a_irq_fall: assert property ($fell(capture_irq) |-> $past(rd_l) || $past(wr_c))
		else $error("interrupt dropped without clear");
	// Main scenarios reached
	c_strobe: cover property ($rose(strobe_output_line));
	c_irq: cover property ($rose(capture_irq));
	c_clear: cover property ($fell(capture_irq));
endmodule

// file: tb/pio_periph.sv
// Peripheral model on the port C lines and the edge input
`timescale 1ns/10ps
module pio_periph (
	// Drive from the block
	input wire pio_pkg::pio_bidir_t port_c_pins,
	// Levels the peripheral offers
	input wire logic [7:0] ext_c,
	input wire logic ext_edge,
	// Resolved levels seen by the block
	output logic [7:0] port_c_in,
	output logic edge_latch_input
);
	// Driven lines show the block, released lines the peripheral
	assign port_c_in = port_c_pins.out & ~port_c_pins.oe_n | ext_c & port_c_pins.oe_n;
	// Edge line, held by the bench for several cycles per level
	assign edge_latch_input = ext_edge;
endmodule

// file: tb/pio_top_tb.sv
// Self-checking bench for the parallel I/O block
`timescale 1ns/10ps
module pio_top_tb;
	localparam int STROBE_CYCLES = 2;
	// Stimulus and observed signals
	logic clk_sys, rst_n, single_chip_mode, port_a7_direction, ext_edge;
	logic port_a7_oe_n, edge_latch_input, strobe_output_line, capture_irq;
	logic [7:0] acc_rdata, port_a_in, port_a_out, port_b_out, port_c_in, port_d_in, port_e_in, ext_c, rv;
	pio_pkg::pio_acc_t acc_req;
	pio_pkg::pio_bidir_t port_c_pins, port_d_pins;
	int error_cnt, n_tests, act;
	pio_top #(.STROBE_CYCLES(STROBE_CYCLES)) u_pio_top (.clk_sys, .rst_n, .single_chip_mode, .port_a7_direction,
		.acc_req, .acc_rdata, .port_a_in, .port_a_out, .port_a7_oe_n, .port_b_out, .port_c_in, .port_c_pins,
		.port_d_in, .port_d_pins, .port_e_in, .edge_latch_input, .strobe_output_line, .capture_irq);
	pio_periph u_pio_periph (.port_c_pins, .ext_c, .ext_edge, .port_c_in, .edge_latch_input);
	// Released port D lines read back the inverse of the last drive
	assign port_d_in = port_d_pins.out & ~port_d_pins.oe_n | ~port_d_pins.out & port_d_pins.oe_n;
	// Clock
	initial begin
		clk_sys = 1'h0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	// Compare and count
	task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// One access held for one edge, answer taken after it
	task automatic acc(input logic w, input logic r, input logic [3:0] idx, input logic [7:0] d);
		@(posedge clk_sys);
		acc_req <= '{w, r, idx, d};
		@(posedge clk_sys);
		acc_req <= '0;
		#1;
		rv = acc_rdata;
	endtask
	task automatic wr(input logic [3:0] idx, input logic [7:0] d);
		acc(1'h1, 1'h0, idx, d);
	endtask
	task automatic rd(input string nm, input logic [3:0] idx, input logic [7:0] exp);
		acc(1'h0, 1'h1, idx, 8'h00);
		check(nm, rv, exp);
	endtask
	// New edge level and port C data, then wait out the sync path
	task automatic edge_to(input logic lvl, input logic [7:0] c);
		@(posedge clk_sys);
		ext_edge <= lvl;
		ext_c <= c;
		repeat (6) @(posedge clk_sys);
		#1;
	endtask
	// Port B write, then count active strobe cycles
	task automatic strobe(input logic [7:0] d, input logic lvl, input int n);
		wr(pio_pkg::IDX_PORT_B, d);
		act = 0;
		for (int i = 0; i < 4; i++) begin
			act += int'(strobe_output_line === lvl);
			@(posedge clk_sys);
			#1;
		end
		check("strobe", 8'(act), 8'(n));
		check("strobe idle", {7'h0, strobe_output_line}, {7'h0, ~lvl});
	endtask
	task automatic summarize;
		$display("Checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// Watchdog
	initial begin
		#20000;
		error_cnt++;
		summarize();
	end
	// Test sequence
	initial begin
		rst_n = 1'h0;
		single_chip_mode = 1'h1;
		port_a7_direction = 1'h0;
		ext_edge = 1'h0;
		ext_c = 8'h5A;
		acc_req = '0;
		port_a_in = 8'h05;
		port_e_in = 8'hC3;
		error_cnt = 0;
		n_tests = 0;
		repeat (8) @(posedge clk_sys);
		rst_n <= 1'h1;
		#1;
		check("dir c", port_c_pins.oe_n, 8'hFF);
		rd("ctrl", pio_pkg::IDX_CTRL, pio_pkg::CTRL_RESET);
		wr(pio_pkg::IDX_PORT_C, 8'hFF);
		check("c held", port_c_pins.oe_n, 8'hFF);
		wr(pio_pkg::IDX_DIR_C, 8'h0F);
		check("c oe", port_c_pins.oe_n, 8'hF0);
		check("c out", port_c_pins.out & 8'h0F, 8'h0F);
		rd("c", pio_pkg::IDX_PORT_C, 8'h5F);
		rd("dir c rd", pio_pkg::IDX_DIR_C, 8'h0F);
		wr(pio_pkg::IDX_CTRL, 8'h23);
		check("c od", port_c_pins.oe_n, 8'hFF);
		wr(pio_pkg::IDX_CTRL, 8'h03);
		wr(pio_pkg::IDX_DIR_D, 8'hAA);
		wr(pio_pkg::IDX_PORT_D, 8'h3C);
		rd("d", pio_pkg::IDX_PORT_D, 8'h69);
		wr(pio_pkg::IDX_PORT_A, 8'hFF);
		check("a out", port_a_out, 8'hF8);
		rd("a", pio_pkg::IDX_PORT_A, 8'h7D);
		@(posedge clk_sys);
		port_a7_direction <= 1'h1;
		rd("a7", pio_pkg::IDX_PORT_A, 8'hFD);
		check("a7 oe", {7'h0, port_a7_oe_n}, 8'h00);
		wr(pio_pkg::IDX_PORT_E, 8'h00);
		rd("e", pio_pkg::IDX_PORT_E, 8'hC3);
		strobe(8'h96, 1'h1, STROBE_CYCLES);
		rd("b", pio_pkg::IDX_PORT_B, 8'h96);
		wr(pio_pkg::IDX_CTRL, 8'h02);
		strobe(8'h69, 1'h0, STROBE_CYCLES);
		wr(pio_pkg::IDX_CTRL, 8'h12);
		strobe(8'h11, 1'h0, 0);
		wr(pio_pkg::IDX_CTRL, 8'h83);
		@(posedge clk_sys);
		single_chip_mode <= 1'h0;
		strobe(8'h22, 1'h1, 0);
		edge_to(1'h1, 8'h99);
		rd("no cap", pio_pkg::IDX_CTRL, 8'h03);
		edge_to(1'h0, 8'h99);
		@(posedge clk_sys);
		single_chip_mode <= 1'h1;
		wr(pio_pkg::IDX_DIR_C, 8'h00);
		edge_to(1'h1, 8'hA5);
		rd("cap", pio_pkg::IDX_LATCHED_C, 8'hA5);
		rd("flag", pio_pkg::IDX_CTRL, 8'h83);
		check("irq off", {7'h0, capture_irq}, 8'h00);
		wr(pio_pkg::IDX_CTRL, 8'hC3);
		check("irq on", {7'h0, capture_irq}, 8'h01);
		edge_to(1'h0, 8'h3C);
		edge_to(1'h1, 8'h3C);
		rd("live", pio_pkg::IDX_PORT_C, 8'h3C);
		rd("recap", pio_pkg::IDX_LATCHED_C, 8'h3C);
		rd("cleared", pio_pkg::IDX_CTRL, 8'h43);
		check("irq clr", {7'h0, capture_irq}, 8'h00);
		wr(pio_pkg::IDX_CTRL, 8'h41);
		edge_to(1'h0, 8'h77);
		rd("fall", pio_pkg::IDX_CTRL, 8'hC1);
		rd("fall cap", pio_pkg::IDX_LATCHED_C, 8'h77);
		edge_to(1'h1, 8'h88);
		rd("rise", pio_pkg::IDX_LATCHED_C, 8'h77);
		summarize();
	end
endmodule
bind pio_top pio_top_checker #(.STROBE_CYCLES(STROBE_CYCLES)) u_pio_top_checker (.clk_sys, .rst_n,
	.port_a7_direction, .acc_req, .acc_rdata, .port_a_in, .port_a_out, .port_a7_oe_n, .port_b_out, .port_c_in,
	.port_c_pins, .port_d_pins, .port_e_in, .edge_latch_input, .strobe_output_line, .capture_irq);
